// File: iowdt_host.sv
`timescale 1ns/1ns
module iowdt_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [15:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // A released bus shows inverted values so that stale data cannot pass for a match.
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask : io_write
  task automatic io_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask : io_read
  task automatic refresh(output logic [7:0] d);
    io_write(16'h0080, 8'h5A);
    io_read(16'h0443, d);
  endtask : refresh
endmodule : iowdt_host

// File: iowdt_pkg.sv
package iowdt_pkg;

  localparam logic [15:0] IOWDT_ADDR_DISABLE = 16'h0080;
  localparam logic [15:0] IOWDT_ADDR_INTERVAL = 16'h0443;
  localparam logic [15:0] IOWDT_ADDR_ACTION = 16'h0444;

  localparam int IOWDT_INTERVAL_UNIT_BIT = 7;
  localparam logic [7:0] IOWDT_INTERVAL_RESET = 8'h00;
  localparam logic [2:0] IOWDT_ACTION_RESET = 3'h0;

  localparam logic [2:0] IOWDT_ACT_SYSRST = 3'h0;
  localparam logic [2:0] IOWDT_ACT_IRQ10 = 3'h1;
  localparam logic [2:0] IOWDT_ACT_IRQ15 = 3'h2;
  localparam logic [2:0] IOWDT_ACT_IRQ11 = 3'h3;
  localparam logic [2:0] IOWDT_ACT_NMI = 3'h4;

  localparam int IOWDT_CLK_HZ = 10000000;
  localparam int IOWDT_TICK_S = 1;
  localparam int IOWDT_TICK_CYCLES = IOWDT_CLK_HZ * IOWDT_TICK_S;
  localparam int IOWDT_SEC_PER_MIN = 60;

  typedef struct packed {
    logic sys_reset;
    logic irq10;
    logic irq15;
    logic irq11;
    logic nmi;
  } iowdt_event_t;

  typedef enum logic [1:0] {
    IOWDT_IDLE = 2'h1,
    IOWDT_RUN = 2'h2
  } iowdt_state_t;

endpackage : iowdt_pkg

// File: iowdt_top.sv
`timescale 1ns/1ns
module iowdt_top
  import iowdt_pkg::*;
#(
  parameter int TICK_CYCLES = IOWDT_TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [15:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_RD,
  output logic [7:0] IO_RDATA,
  output logic RUNNING,
  output iowdt_event_t EVENT_OUT
);

  // The tick must be a single-cycle pulse, which needs at least two cycles per second.
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least two");
  end

  localparam int CW = 24;
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  // Total seconds for an interval byte; zero means no time-out.
  function automatic logic [CW-1:0] interval_seconds(input logic [7:0] iv);
    logic [CW-1:0] n;
    n = CW'(iv[6:0]);
    if (iv[IOWDT_INTERVAL_UNIT_BIT]) begin
      interval_seconds = CW'(n * CW'(IOWDT_SEC_PER_MIN));
    end else begin
      interval_seconds = n;
    end
  endfunction : interval_seconds

  logic wr_disable;
  logic wr_interval;
  logic wr_action;
  logic rd_interval;
  assign wr_disable = IO_WR && (IO_ADDR == IOWDT_ADDR_DISABLE);
  assign wr_interval = IO_WR && (IO_ADDR == IOWDT_ADDR_INTERVAL);
  assign wr_action = IO_WR && (IO_ADDR == IOWDT_ADDR_ACTION);
  assign rd_interval = IO_RD && (IO_ADDR == IOWDT_ADDR_INTERVAL);

  logic [7:0] interval_reg;
  logic [2:0] action_reg;
  iowdt_state_t state_reg;
  logic [CW-1:0] count_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  logic expire;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      interval_reg <= IOWDT_INTERVAL_RESET;
    end else if (wr_interval) begin
      interval_reg <= IO_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      action_reg <= IOWDT_ACTION_RESET;
    end else if (wr_action) begin
      action_reg <= IO_WDATA[2:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IO_RDATA <= 8'h00;
    end else if (rd_interval) begin
      IO_RDATA <= interval_reg;
    end
  end

  // The tick prescaler restarts on every reload so the first second is whole.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tick_cnt_reg <= '0;
    end else if (rd_interval || state_reg != IOWDT_RUN || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
    end
  end
  assign tick = (state_reg == IOWDT_RUN) && (tick_cnt_reg == TW'(TICK_CYCLES - 1));

  assign expire = (state_reg == IOWDT_RUN) && tick && (count_reg == CW'(1)) && !wr_disable
    && !rd_interval;

  // A disable write wins over a same-cycle read; that read does not reload, so the timer stays idle.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= IOWDT_IDLE;
      count_reg <= '0;
    end else if (wr_disable) begin
      state_reg <= IOWDT_IDLE;
    end else if (rd_interval) begin
      state_reg <= IOWDT_RUN;
      count_reg <= interval_seconds(interval_reg);
    end else begin
      case (state_reg)
        IOWDT_IDLE: begin
          state_reg <= IOWDT_IDLE;
        end
        IOWDT_RUN: begin
          if (expire) begin
            state_reg <= IOWDT_IDLE;
            count_reg <= '0;
          end else if (tick && count_reg != '0) begin
            count_reg <= count_reg - CW'(1);
          end
        end
        default: begin
          state_reg <= IOWDT_IDLE;
        end
      endcase
    end
  end

  // Expiry raises the selected action as a one-cycle pulse.
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      EVENT_OUT <= '0;
    end else begin
      EVENT_OUT <= '0;
      if (expire) begin
        case (action_reg)
          IOWDT_ACT_SYSRST: EVENT_OUT.sys_reset <= 1'b1;
          IOWDT_ACT_IRQ10: EVENT_OUT.irq10 <= 1'b1;
          IOWDT_ACT_IRQ15: EVENT_OUT.irq15 <= 1'b1;
          IOWDT_ACT_IRQ11: EVENT_OUT.irq11 <= 1'b1;
          IOWDT_ACT_NMI: EVENT_OUT.nmi <= 1'b1;
          default: EVENT_OUT <= '0;
        endcase
      end
    end
  end

  assign RUNNING = (state_reg == IOWDT_RUN);

  chk_interval_load: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_interval |=> interval_reg == $past(IO_WDATA))
    else $error("interval not loaded");
  chk_action_load: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_action |=> action_reg == $past(IO_WDATA[2:0]))
    else $error("action not loaded");
  chk_disable_stops: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_disable |=> !RUNNING && EVENT_OUT == '0)
    else $error("disable did not stop");
  chk_read_reload: assert property (@(posedge CLK) disable iff (!ARST_N)
    rd_interval && !wr_disable |=> RUNNING && tick_cnt_reg == '0 && IO_RDATA == $past(interval_reg))
    else $error("read did not reload");
  chk_rdata_holds: assert property (@(posedge CLK) disable iff (!ARST_N)
    !rd_interval |=> $stable(IO_RDATA))
    else $error("read data changed without a read");
  chk_seconds_mode: assert property (@(posedge CLK) disable iff (!ARST_N)
    rd_interval && !wr_disable && !interval_reg[7] |=> count_reg == CW'($past(interval_reg[6:0])))
    else $error("seconds count wrong");
  chk_minutes_mode: assert property (@(posedge CLK) disable iff (!ARST_N)
    rd_interval && !wr_disable && interval_reg[7]
    |=> count_reg == CW'($past(interval_reg[6:0])) * CW'(60))
    else $error("minutes count wrong");
  chk_expiry_event: assert property (@(posedge CLK) disable iff (!ARST_N)
    expire && action_reg == IOWDT_ACT_NMI |=> EVENT_OUT.nmi && !RUNNING)
    else $error("expiry action wrong");
  chk_event_cause: assert property (@(posedge CLK) disable iff (!ARST_N)
    EVENT_OUT != '0 |-> $past(expire))
    else $error("event without expiry");
  chk_tick_period: assert property (@(posedge CLK) disable iff (!ARST_N)
    tick |=> !tick)
    else $error("tick too fast");
  chk_idle_quiet: assert property (@(posedge CLK) disable iff (!ARST_N)
    !RUNNING && !rd_interval |=> !RUNNING)
    else $error("started without read");
  chk_zero_never: assert property (@(posedge CLK) disable iff (!ARST_N)
    RUNNING && count_reg == '0 && !wr_disable && !rd_interval
    |=> RUNNING && count_reg == '0 && EVENT_OUT == '0)
    else $error("zero interval expired");
  chk_count_step: assert property (@(posedge CLK) disable iff (!ARST_N)
    tick && count_reg > CW'(1) && !wr_disable && !rd_interval
    |=> RUNNING && count_reg == $past(count_reg) - CW'(1))
    else $error("count did not step on tick");

  // Each listed action code drives exactly one event line; codes above NMI stay silent.
  chk_reset_event: assert property (@(posedge CLK) disable iff (!ARST_N)
    expire && action_reg == IOWDT_ACT_SYSRST |=> EVENT_OUT == iowdt_event_t'(5'h10))
    else $error("reset action wrong");
  chk_irq10_event: assert property (@(posedge CLK) disable iff (!ARST_N)
    expire && action_reg == IOWDT_ACT_IRQ10 |=> EVENT_OUT == iowdt_event_t'(5'h08))
    else $error("first interrupt action wrong");
  chk_irq15_event: assert property (@(posedge CLK) disable iff (!ARST_N)
    expire && action_reg == IOWDT_ACT_IRQ15 |=> EVENT_OUT == iowdt_event_t'(5'h04))
    else $error("second interrupt action wrong");
  chk_irq11_event: assert property (@(posedge CLK) disable iff (!ARST_N)
    expire && action_reg == IOWDT_ACT_IRQ11 |=> EVENT_OUT == iowdt_event_t'(5'h02))
    else $error("third interrupt action wrong");
  chk_unused_action: assert property (@(posedge CLK) disable iff (!ARST_N)
    expire && action_reg > IOWDT_ACT_NMI |=> EVENT_OUT == '0 && !RUNNING)
    else $error("unlisted action raised an event");

  // Scenarios that the bench reaches, except cov_refresh: the bench reads two cycles after the disable write, not one.
  cov_reset_event: cover property (@(posedge CLK) disable iff (!ARST_N) EVENT_OUT.sys_reset);
  cov_nmi_event: cover property (@(posedge CLK) disable iff (!ARST_N) EVENT_OUT.nmi);
  cov_minutes_load: cover property (@(posedge CLK) disable iff (!ARST_N)
    rd_interval && interval_reg[IOWDT_INTERVAL_UNIT_BIT]);
  cov_irq_event: cover property (@(posedge CLK) disable iff (!ARST_N) EVENT_OUT.irq15);
  cov_refresh: cover property (@(posedge CLK) disable iff (!ARST_N)
    RUNNING && wr_disable ##1 rd_interval);

endmodule : iowdt_top

// File: iowdt_top_tb.sv
`timescale 1ns/1ns
module iowdt_top_tb;
  import iowdt_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, running;
  iowdt_event_t ev_out, ev;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  always #50 clk = ~clk;
  iowdt_top #(.TICK_CYCLES(4)) i_dut (.CLK(clk), .ARST_N(arst_n), .IO_ADDR(addr),
    .IO_WDATA(wdata), .IO_WR(wr), .IO_RD(rd), .IO_RDATA(rdata), .RUNNING(running),
    .EVENT_OUT(ev_out));
  iowdt_host i_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wait_ev(input int lim);
    n = 0;
    ev = '0;
    while (ev === '0 && n < lim) begin
      @(posedge clk);
      #1;
      ev = ev_out;
      n++;
    end
  endtask : wait_ev
  task automatic final_report();
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(running === 1'b0 && ev_out === '0 && rdata === 8'h00, "not idle after reset");
    for (int a = 0; a < 5; a++) begin
      i_host.io_write(IOWDT_ADDR_ACTION, 8'(a));
      i_host.io_write(IOWDT_ADDR_INTERVAL, 8'h02);
      i_host.io_write(16'h0442, 8'h7F);
      i_host.io_read(IOWDT_ADDR_INTERVAL, d);
      chk(d === 8'h02 && running === 1'b1, "interval not loaded");
      wait_ev(20);
      chk(n >= 7 && n <= 11, "seconds timing");
      chk(ev === iowdt_event_t'(5'h10 >> a) && running === 1'b0, "wrong action");
    end
    i_host.io_write(IOWDT_ADDR_INTERVAL, 8'h81);
    i_host.io_read(IOWDT_ADDR_INTERVAL, d);
    wait_ev(300);
    chk(d === 8'h81 && n >= 236 && n <= 245, "minutes timing");
    i_host.io_write(IOWDT_ADDR_INTERVAL, 8'h03);
    i_host.io_read(IOWDT_ADDR_INTERVAL, d);
    wait_ev(8);
    chk(ev === '0, "early expiry");
    i_host.refresh(d);
    wait_ev(20);
    chk(n >= 10 && n <= 14 && ev === iowdt_event_t'(5'h01), "refresh failed");
    i_host.io_read(IOWDT_ADDR_INTERVAL, d);
    i_host.io_write(IOWDT_ADDR_DISABLE, 8'hA5);
    wait_ev(30);
    chk(ev === '0 && running === 1'b0, "disable failed");
    for (int k = 0; k < 2; k++) begin
      i_host.io_write(IOWDT_ADDR_INTERVAL, 8'(k * 128));
      i_host.io_read(IOWDT_ADDR_INTERVAL, d);
      wait_ev(60);
      chk(ev === '0 && running === 1'b1, "undefined interval expired");
      i_host.io_write(IOWDT_ADDR_DISABLE, 8'h00);
    end
    i_host.io_read(IOWDT_ADDR_INTERVAL, d);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk(running === 1'b0 && ev_out === '0 && rdata === 8'h00, "not idle after reset");
    i_host.io_read(IOWDT_ADDR_INTERVAL, d);
    wait_ev(8);
    chk(d === 8'h00 && running === 1'b1 && ev === '0, "cleared interval expired");
    i_host.io_write(IOWDT_ADDR_ACTION, 8'h05);
    i_host.io_write(IOWDT_ADDR_INTERVAL, 8'h01);
    i_host.io_write(IOWDT_ADDR_DISABLE, 8'h00);
    i_host.io_read(IOWDT_ADDR_INTERVAL, d);
    wait_ev(10);
    chk(d === 8'h01 && ev === '0 && running === 1'b0, "unlisted action raised event");
    final_report();
  end
endmodule : iowdt_top_tb
